// [alp_pkg.sv]
// Package for the absolute linear position report block.
// Holds framing, character codes and timing constants shared by all files but the host model.
package alp_pkg;

   // ------------------------------------------------------------
   // Clock and serial timing
   // ------------------------------------------------------------
   localparam int CLK_HZ       = 50_000_000;
   localparam int BAUD_BPS     = 9_600;
   // Bit time rounded down to whole cycles (5208 at 50 MHz).
   localparam int BIT_CYCLES   = CLK_HZ / BAUD_BPS;
   // Quarter period of the lower-part quadrature train, in ns.
   localparam int STEP_NS      = 500;
   localparam int STEP_CYCLES  = (STEP_NS * (CLK_HZ / 1_000_000)) / 1_000;

   // ------------------------------------------------------------
   // Position layout
   // ------------------------------------------------------------
   localparam int POS_W        = 36;
   localparam int UPPER_W      = 16;
   localparam int LOWER_W      = 20;
   localparam int DIV_W        = 16;
   localparam int CHAR_W       = 7;
   localparam int MSG_LEN      = 8;
   localparam int DIGITS       = 5;

   // ------------------------------------------------------------
   // Message characters (7-bit ASCII)
   // ------------------------------------------------------------
   localparam logic [6:0] CH_P     = 7'h50;
   localparam logic [6:0] CH_PLUS  = 7'h2B;
   localparam logic [6:0] CH_MINUS = 7'h2D;
   localparam logic [6:0] CH_ZERO  = 7'h30;
   localparam logic [6:0] CH_CR    = 7'h0D;

   // Usage setting encoding: absolute or incremental encoder.
   localparam logic USE_ABSOLUTE    = 1'b0;
   localparam logic USE_INCREMENTAL = 1'b1;

   // Report sequencer states.
   typedef enum logic [2:0] {
      ALP_ST_START,
      ALP_ST_DIVIDE,
      ALP_ST_DIGITS,
      ALP_ST_SEND,
      ALP_ST_PULSE,
      ALP_ST_INCR
   } alp_state_e;

endpackage

// [alp_tx_if.sv]
// Interface carrying one character request to the serial transmitter.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface alp_tx_if;
   import alp_pkg::*;

   logic               start;
   logic [CHAR_W-1:0]  ch;
   logic               busy;
   logic               line;

   modport seq (output start, output ch, input busy, input line);
   modport tx  (input start, input ch, output busy, output line);
endinterface

// [alp_uart_tx.sv]
// Start-stop transmitter: 1 start, 7 data LSB first, even parity, 1 stop.
// Assumes one clock; start is honoured only while busy is low.
`timescale 1ns/1ps
module alp_uart_tx #(
   parameter int BIT_CYC = alp_pkg::BIT_CYCLES
) (
   input  wire logic clk,
   input  wire logic arst_n,
   alp_tx_if.tx      txp
);
   import alp_pkg::*;

   localparam int FRAME_BITS = CHAR_W + 3;

   logic [FRAME_BITS-1:0] shift_r;
   logic [3:0]            bits_r;
   logic [31:0]           tick_r;
   logic                  line_r;

   assign txp.busy = (bits_r != 4'h0);
   assign txp.line = line_r;

   // ------------------------------------------------------------
   // Frame shifter
   // ------------------------------------------------------------
   // Loads a frame on start and shifts one bit per bit time.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         shift_r <= '1;
         bits_r  <= 4'h0;
         tick_r  <= 32'h0;
         line_r  <= 1'b1;
      end else if (bits_r == 4'h0) begin
         line_r <= 1'b1;                    // Idle line is high (mark).
         if (txp.start) begin
            // Stop, even parity, data, start.
            shift_r <= {1'b1, ^txp.ch, txp.ch, 1'b0};
            bits_r  <= 4'(FRAME_BITS);
            tick_r  <= 32'h0;
         end
      end else begin
         line_r <= shift_r[0];
         if (tick_r == 32'(BIT_CYC - 1)) begin
            tick_r  <= 32'h0;
            shift_r <= {1'b1, shift_r[FRAME_BITS-1:1]};
            bits_r  <= bits_r - 4'h1;
         end else begin
            tick_r <= tick_r + 32'h1;
         end
      end
   end
endmodule

// [alp_report.sv]
// Absolute linear position report on the divided pulse outputs.
// Assumes position, settings and incremental pulses are synchronous to clk.
`timescale 1ns/1ps

// How it works
// - Position is a signed 36-bit pulse count from the encoder origin.
// - The stopped position present at start-up is captured and reported.
// - Upper 16 bits go serially, lower 20 bits go as pulses, separately.
// - Report starts on phase A by itself after reset release.
// - Phase A: serial message, then lower-part pulses, then incremental.
// - Phase B held low during message, then lower pulses, then incremental.
// - Only phase A toggles during the message, so counters see nothing.
// - 9600 bps, one start, seven data, even parity, one stop bit.
// - Message is sent once per reset, never repeated.
// - Eight characters: P, sign, five digits, carriage return.
// - Usage setting latched at restart; incremental use skips the report.
// - Both parts come from the position divided by the divider setting.
module alp_report #(
   parameter int BIT_CYC  = alp_pkg::BIT_CYCLES,
   parameter int STEP_CYC = alp_pkg::STEP_CYCLES
) (
   input  wire logic                      clk,
   input  wire logic                      arst_n,
   input  wire logic [alp_pkg::POS_W-1:0] position,
   input  wire logic                      encoder_usage_setting,
   input  wire logic [alp_pkg::DIV_W-1:0] pulse_divider_setting,
   input  wire logic                      inc_phase_a,
   input  wire logic                      inc_phase_b,
   input  wire logic                      inc_origin,
   output logic                           divided_phase_a_out,
   output logic                           divided_phase_b_out,
   output logic                           origin_pulse_out,
   output logic                           report_done
);
   import alp_pkg::*;

   alp_tx_if txc ();

   alp_state_e             state_r;
   logic                   last_r;
   logic                   neg_r;
   logic [POS_W-1:0]       mag_r;
   logic [POS_W-1:0]       quo_r;
   logic [DIV_W:0]         rem_r;
   logic [DIV_W-1:0]       dvs_r;
   logic [5:0]             dcnt_r;
   logic [POS_W-1:0]       scaled;
   logic [UPPER_W-1:0]     upper_r;
   logic                   up_neg_r;
   logic [UPPER_W:0]       dig_rem_r;
   logic [2:0]             dig_idx_r;
   logic [3:0]             dig_val_r;
   logic [3:0]             digits_r [DIGITS];
   logic [2:0]             char_idx_r;
   logic                   wait_r;
   logic [LOWER_W-1:0]     pcnt_r;
   logic [1:0]             step_r;
   logic [31:0]            stick_r;
   logic [DIV_W:0]         rem_sh;
   logic [UPPER_W:0]       pow10;
   logic [UPPER_W:0]       up_mag;

   alp_uart_tx #(
      .BIT_CYC (BIT_CYC)
   ) u_tx (
      .clk    (clk),
      .arst_n (arst_n),
      .txp    (txc.tx)
   );

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   // Power of ten for the digit being extracted, top digit first.
   always_comb begin
      case (dig_idx_r)
         3'h0:    pow10 = 17'(10000);
         3'h1:    pow10 = 17'(1000);
         3'h2:    pow10 = 17'(100);
         3'h3:    pow10 = 17'(10);
         default: pow10 = 17'(1);
      endcase
   end

   // Shift step of the restoring divider.
   assign rem_sh = {rem_r[DIV_W-1:0], mag_r[POS_W-1]};

   // Signed quotient; the upper and lower parts split from it.
   assign scaled = neg_r ? (~quo_r + 36'h1) : quo_r;

   // Magnitude of the signed upper part (up to 32768).
   assign up_mag = up_neg_r ? (17'h0 - {1'b1, upper_r})
                            : {1'b0, upper_r};

   // Character chosen for the current message slot.
   always_comb begin
      txc.ch = CH_CR;
      case (char_idx_r)
         3'h0:    txc.ch = CH_P;
         3'h1:    txc.ch = up_neg_r ? CH_MINUS : CH_PLUS;
         3'h7:    txc.ch = CH_CR;
         default: txc.ch = CH_ZERO + 7'(digits_r[char_idx_r - 3'h2]);
      endcase
   end

   // Issue a character when the transmitter is free and none is pending.
   assign txc.start = (state_r == ALP_ST_SEND) && !txc.busy && !wait_r
                      && !last_r;

   // ------------------------------------------------------------
   // Sequencer
   // ------------------------------------------------------------
   // Walks the one-time report and then stays in incremental mode.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         state_r <= ALP_ST_START;
      end else begin
         case (state_r)
            ALP_ST_START: begin
               if (encoder_usage_setting == USE_INCREMENTAL) begin
                  state_r <= ALP_ST_INCR;
               end else begin
                  state_r <= ALP_ST_DIVIDE;
               end
            end
            ALP_ST_DIVIDE: begin
               if (dcnt_r == 6'h0) begin
                  state_r <= ALP_ST_DIGITS;
               end
            end
            ALP_ST_DIGITS: begin
               if (dig_idx_r == 3'(DIGITS)) begin
                  state_r <= ALP_ST_SEND;
               end
            end
            ALP_ST_SEND: begin
               // Leaves only once the closing frame has fully gone out.
               if (last_r && !txc.busy) begin
                  state_r <= ALP_ST_PULSE;
               end
            end
            ALP_ST_PULSE: begin
               if (pcnt_r == '0 && step_r == 2'h0) begin
                  state_r <= ALP_ST_INCR;
               end
            end
            ALP_ST_INCR: begin
               state_r <= ALP_ST_INCR;
            end
            default: begin
               state_r <= ALP_ST_START;
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // Capture and division
   // ------------------------------------------------------------
   // Captures the stopped position and divider, then divides the magnitude.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         neg_r   <= 1'b0;
         mag_r   <= '0;
         quo_r   <= '0;
         rem_r   <= '0;
         dvs_r   <= '0;
         dcnt_r  <= 6'h0;
      end else if (state_r == ALP_ST_START) begin
         neg_r   <= position[POS_W-1];
         mag_r   <= position[POS_W-1] ? (~position + 36'h1)
                                      : position;
         quo_r   <= '0;
         rem_r   <= '0;
         // A zero divider is taken as one.
         dvs_r   <= (pulse_divider_setting == '0) ? DIV_W'(1)
                                                  : pulse_divider_setting;
         dcnt_r  <= 6'(POS_W);
      end else if (state_r == ALP_ST_DIVIDE && dcnt_r != 6'h0) begin
         mag_r  <= {mag_r[POS_W-2:0], 1'b0};
         dcnt_r <= dcnt_r - 6'h1;
         if (rem_sh >= {1'b0, dvs_r}) begin
            rem_r <= rem_sh - {1'b0, dvs_r};
            quo_r <= {quo_r[POS_W-2:0], 1'b1};
         end else begin
            rem_r <= rem_sh;
            quo_r <= {quo_r[POS_W-2:0], 1'b0};
         end
      end
   end

   // ------------------------------------------------------------
   // Decimal digits of the upper part
   // ------------------------------------------------------------
   // Splits the quotient and extracts digits by repeated subtraction.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         upper_r   <= '0;
         up_neg_r  <= 1'b0;
         dig_rem_r <= '0;
         dig_idx_r <= 3'h0;
         dig_val_r <= 4'h0;
         for (int i = 0; i < DIGITS; i++) begin
            digits_r[i] <= 4'h0;
         end
      end else if (state_r == ALP_ST_DIVIDE) begin
         upper_r   <= scaled[POS_W-1:LOWER_W];
         up_neg_r  <= scaled[POS_W-1];
         dig_idx_r <= 3'h0;
         dig_val_r <= 4'hF;              // Load pending; zero is legal.
         dig_rem_r <= '0;
      end else if (state_r == ALP_ST_DIGITS
                   && dig_idx_r != 3'(DIGITS)) begin
         if (dig_val_r == 4'hF) begin
            dig_rem_r <= up_mag;
            dig_val_r <= 4'h0;
         end else if (dig_rem_r >= pow10) begin
            dig_rem_r <= dig_rem_r - pow10;
            dig_val_r <= dig_val_r + 4'h1;
         end else begin
            digits_r[dig_idx_r] <= dig_val_r;
            dig_idx_r <= dig_idx_r + 3'h1;
            dig_val_r <= 4'h0;
         end
      end
   end

   // ------------------------------------------------------------
   // Message sending
   // ------------------------------------------------------------
   // Steps through the eight characters, one frame at a time.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         char_idx_r <= 3'h0;
         wait_r     <= 1'b0;
         last_r     <= 1'b0;
      end else if (state_r == ALP_ST_SEND) begin
         if (txc.start) begin
            wait_r <= 1'b1;
         end else if (wait_r && txc.busy) begin
            // The frame is latched, so the next slot may be selected.
            wait_r <= 1'b0;
            if (char_idx_r == 3'(MSG_LEN - 1)) begin
               last_r <= 1'b1;
            end else begin
               char_idx_r <= char_idx_r + 3'h1;
            end
         end
      end
   end

   // ------------------------------------------------------------
   // Lower-part pulse train
   // ------------------------------------------------------------
   // Emits the lower 20 bits as forward quadrature cycles.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         pcnt_r  <= '0;
         step_r  <= 2'h0;
         stick_r <= 32'h0;
      end else if (state_r == ALP_ST_DIGITS) begin
         pcnt_r  <= scaled[LOWER_W-1:0];
         step_r  <= 2'h0;
         stick_r <= 32'h0;
      end else if (state_r == ALP_ST_PULSE) begin
         if (stick_r == 32'(STEP_CYC - 1)) begin
            stick_r <= 32'h0;
            if (step_r != 2'h0 || pcnt_r != '0) begin
               step_r <= step_r + 2'h1;
               if (step_r == 2'h0) begin
                  pcnt_r <= pcnt_r - 20'h1;
               end
            end
         end else begin
            stick_r <= stick_r + 32'h1;
         end
      end
   end

   // ------------------------------------------------------------
   // Output pins
   // ------------------------------------------------------------
   // Selects what each phase output shows in each stage.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         divided_phase_a_out <= 1'b1;
         divided_phase_b_out <= 1'b0;
      end else begin
         case (state_r)
            ALP_ST_SEND: begin
               divided_phase_a_out <= txc.line;
               divided_phase_b_out <= 1'b0;
            end
            ALP_ST_PULSE: begin
               // Phase A leads B: 00, 10, 11, 01.
               divided_phase_a_out <= (step_r == 2'h1) || (step_r == 2'h2);
               divided_phase_b_out <= step_r[1];
            end
            ALP_ST_INCR: begin
               divided_phase_a_out <= inc_phase_a;
               divided_phase_b_out <= inc_phase_b;
            end
            default: begin
               divided_phase_a_out <= 1'b1;
               divided_phase_b_out <= 1'b0;
            end
         endcase
      end
   end

   // Origin pulses pass through in every stage.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         origin_pulse_out <= 1'b0;
      end else begin
         origin_pulse_out <= inc_origin;
      end
   end

   // Marks that the report is over or was skipped.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         report_done <= 1'b0;
      end else begin
         report_done <= (state_r == ALP_ST_INCR);
      end
   end

endmodule

// [alp_report_checker.sv]
// Concurrent checks on the ports of the position report block.
// Assumes it is bound to alp_report and sees only that module's ports.
`timescale 1ns/1ps
module alp_report_checker #(
   parameter int BIT_CYC  = alp_pkg::BIT_CYCLES,
   parameter int STEP_CYC = alp_pkg::STEP_CYCLES
) (
   input wire logic                      clk,
   input wire logic                      arst_n,
   input wire logic [alp_pkg::POS_W-1:0] position,
   input wire logic                      encoder_usage_setting,
   input wire logic [alp_pkg::DIV_W-1:0] pulse_divider_setting,
   input wire logic                      inc_phase_a,
   input wire logic                      inc_phase_b,
   input wire logic                      inc_origin,
   input wire logic                      divided_phase_a_out,
   input wire logic                      divided_phase_b_out,
   input wire logic                      origin_pulse_out,
   input wire logic                      report_done
);
   import alp_pkg::*;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);
   int   since_r;
   logic b_seen_r;

   // Counts cycles since release, saturating after one full message.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) since_r <= 0;
      else if (since_r < 80 * BIT_CYC) since_r <= since_r + 1;
   end

   // Remembers that phase B has been high since release.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) b_seen_r <= 1'b0;
      else if (divided_phase_b_out) b_seen_r <= 1'b1;
   end

   // ------------------------------------------------------------
   // Properties
   // ------------------------------------------------------------
   property p_origin;
      $past(arst_n) |-> origin_pulse_out == $past(inc_origin);
   endproperty
   property p_idle;
      $rose(arst_n) && !encoder_usage_setting |-> divided_phase_a_out [*8];
   endproperty
   property p_start_bit;
      // The window closes before the train, whose first step drops A.
      $fell(divided_phase_a_out) && !report_done && !b_seen_r
         && since_r < 70 * BIT_CYC |=> !divided_phase_a_out [*7];
   endproperty
   property p_b_quiet;
      $rose(divided_phase_b_out) && !report_done |-> since_r >= 80 * BIT_CYC;
   endproperty
   property p_one_edge;
      !report_done |->
         !($changed(divided_phase_a_out) && $changed(divided_phase_b_out));
   endproperty
   property p_forward;
      $rose(divided_phase_b_out) && !report_done |-> divided_phase_a_out;
   endproperty
   property p_pass_a;
      report_done && $past(report_done)
         |-> divided_phase_a_out == $past(inc_phase_a);
   endproperty
   property p_pass_b;
      report_done && $past(report_done)
         |-> divided_phase_b_out == $past(inc_phase_b);
   endproperty
   property p_done_holds;
      report_done |=> report_done;
   endproperty
   property p_incr_skip;
      $rose(arst_n) && encoder_usage_setting |-> ##[1:8] report_done;
   endproperty

   a_origin: assert property (p_origin)
      else $error("origin output does not follow its source");
   a_idle: assert property (p_idle)
      else $error("phase A not idle high after release");
   a_start_bit: assert property (p_start_bit)
      else $error("start bit shorter than a bit time");
   a_b_quiet: assert property (p_b_quiet)
      else $error("phase B moved during the message");
   a_one_edge: assert property (p_one_edge)
      else $error("phases A and B changed together");
   a_forward: assert property (p_forward)
      else $error("lower train pulse not in forward order");
   a_pass_a: assert property (p_pass_a)
      else $error("phase A not passing incremental pulses");
   a_pass_b: assert property (p_pass_b)
      else $error("phase B not passing incremental pulses");
   a_done_holds: assert property (p_done_holds)
      else $error("report restarted without reset");
   a_incr_skip: assert property (p_incr_skip)
      else $error("incremental use still sends a report");

   c_done: cover property ($rose(report_done));
   c_frame: cover property ($fell(divided_phase_a_out) && !b_seen_r);
   c_train: cover property ($rose(divided_phase_b_out) && !report_done);
endmodule

bind alp_report alp_report_checker #(
   .BIT_CYC(BIT_CYC),
   .STEP_CYC(STEP_CYC)
) u_chk (
   .clk(clk),
   .arst_n(arst_n),
   .position(position),
   .encoder_usage_setting(encoder_usage_setting),
   .pulse_divider_setting(pulse_divider_setting),
   .inc_phase_a(inc_phase_a),
   .inc_phase_b(inc_phase_b),
   .inc_origin(inc_origin),
   .divided_phase_a_out(divided_phase_a_out),
   .divided_phase_b_out(divided_phase_b_out),
   .origin_pulse_out(origin_pulse_out),
   .report_done(report_done)
);

// [alp_host_model.sv]
// Host side: serial receiver on phase A and a quadrature pulse counter.
// Assumes the lines are sampled on the block's own clock.
`timescale 1ns/1ps
module alp_host_model #(
   parameter int BIT_CYC = 8
) (
   input  wire logic          clk,
   input  wire logic          line_a,
   input  wire logic          line_b,
   input  wire logic          listen,
   input  wire logic          clr,
   output logic [6:0]         chars [0:15],
   output int                 nchar,
   output int                 bad,
   output logic signed [31:0] pulses
);
   logic       a_q;
   logic       b_q;
   logic [7:0] sh;

   // Takes one frame per falling edge, sampling each bit in its middle.
   always @(posedge clk) begin
      if (clr) begin
         nchar = 0;
         bad = 0;
      end else if (listen && (nchar == 0 || chars[nchar - 1] != 7'h0D)
                   && a_q && !line_a) begin
         // Stops listening after the carriage return ends the message.
         repeat (BIT_CYC / 2) @(posedge clk);
         if (line_a) bad = bad + 1;
         for (int i = 0; i < 8; i++) begin
            repeat (BIT_CYC) @(posedge clk);
            sh[i] = line_a;
         end
         repeat (BIT_CYC) @(posedge clk);
         if (!line_a || ^sh) bad = bad + 1;
         if (nchar < 16) chars[nchar] = sh[6:0];
         nchar = nchar + 1;
      end
   end

   // Counts one pulse per rise of B; A high means forward.
   always @(posedge clk) begin
      a_q <= line_a;
      b_q <= line_b;
      if (clr) pulses <= '0;
      else if (line_b && !b_q) pulses <= line_a ? pulses + 1 : pulses - 1;
   end
endmodule

// [tb_absolute_linear_position_output.sv]
// Self-checking bench for the position report block and its host.
// Assumes a 50 MHz clock and shortened bit and step times.
`timescale 1ns/1ps
module tb_absolute_linear_position_output;
   import alp_pkg::*;
   localparam int BIT  = 8;
   localparam int STEP = 2;
   logic               clk    = 1'b0;
   logic               arst_n = 1'b0;
   logic [POS_W-1:0]   pos_i  = '0;
   logic               use_i  = 1'b0;
   logic [DIV_W-1:0]   div_i  = 16'h0001;
   logic               ia     = 1'b0;
   logic               ib     = 1'b0;
   logic               io     = 1'b0;
   logic               listen = 1'b1;
   logic               clr    = 1'b1;
   logic               pa;
   logic               pb;
   logic               po;
   logic               done;
   logic [6:0]         chars [0:15];
   int                 nchar;
   int                 bad;
   logic signed [31:0] pulses;
   int                 fails = 0;
   int                 samples_checked = 0;

   always #10 clk = ~clk;

   alp_report #(.BIT_CYC(BIT), .STEP_CYC(STEP)) uut (
      .clk(clk), .arst_n(arst_n), .position(pos_i),
      .encoder_usage_setting(use_i), .pulse_divider_setting(div_i),
      .inc_phase_a(ia), .inc_phase_b(ib), .inc_origin(io),
      .divided_phase_a_out(pa), .divided_phase_b_out(pb),
      .origin_pulse_out(po), .report_done(done));

   alp_host_model #(.BIT_CYC(BIT)) u_host (
      .clk(clk), .line_a(pa), .line_b(pb), .listen(listen), .clr(clr),
      .chars(chars), .nchar(nchar), .bad(bad), .pulses(pulses));

   // ------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------
   task automatic tick(int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic check(string what, logic [63:0] seen, logic [63:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fails++;
         $display("Error %s expected %0h seen %0h", what, exp, seen);
      end
   endtask

   task automatic stop_test();
      $display("checked %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   task automatic restart(logic u, logic [POS_W-1:0] p, logic [15:0] d);
      arst_n = 1'b0;
      use_i = u;
      pos_i = p;
      div_i = d;
      clr = 1'b1;
      listen = 1'b1;
      tick(20);
      clr = 1'b0;
      arst_n = 1'b1;
   endtask

   // Waits for the report to finish, giving up after lim cycles.
   task automatic wait_done(int lim);
      int n;
      n = 0;
      while (done !== 1'b1 && n < lim) begin
         tick(1);
         n++;
      end
      check("report_done", done, 1'b1);
      if (done !== 1'b1) stop_test();
   endtask

   // One forward incremental pulse with an origin mark on its first step.
   task automatic inc_pulse();
      io = 1'b1;
      ia = 1'b1;
      tick(2);
      check("origin_pulse_out", po, 1'b1);
      check("divided_phase_a_out", pa, 1'b1);
      io = 1'b0;
      ib = 1'b1;
      tick(2);
      ia = 1'b0;
      tick(2);
      ib = 1'b0;
      tick(3);
   endtask

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_abs(logic [POS_W-1:0] p, logic [15:0] d);
      longint             a;
      int                 dv;
      logic signed [15:0] up;
      logic [19:0]        lo;
      logic signed [63:0] rx;
      int                 m;
      dv = d;
      a = longint'($signed(p));
      if (a < 0) a = -a;
      a = a / dv;
      if ($signed(p) < 0) a = -a;
      up = a[35:20];
      lo = a[19:0];
      m = up < 0 ? -up : up;
      restart(1'b0, p, d);
      wait_done(3000);
      tick(BIT * 12);
      check("nchar", nchar, 8);
      check("frame errors", bad, 0);
      check("char P", chars[0], CH_P);
      check("sign", chars[1], up < 0 ? CH_MINUS : CH_PLUS);
      for (int i = 6; i >= 2; i--) begin
         check("digit", chars[i], CH_ZERO + m % 10);
         m = m / 10;
      end
      check("char CR", chars[7], CH_CR);
      check("lower pulses", pulses, lo);
      rx = 0;
      for (int i = 2; i < 7; i++) rx = rx * 10 + (chars[i] - CH_ZERO);
      if (chars[1] == CH_MINUS) rx = -rx;
      check("rebuilt", rx * 1048576 + pulses, a);
      listen = 1'b0;
      inc_pulse();
      check("pulses after", pulses, lo + 1);
      $display("test absolute %0h done", p);
   endtask

   task automatic t_incr();
      ia = 1'b1;
      restart(1'b1, 36'h000100005, 16'h0001);
      wait_done(8);
      tick(BIT * 12);
      check("nchar", nchar, 0);
      check("pulses", pulses, 0);
      listen = 1'b0;
      ia = 1'b0;
      tick(2);
      inc_pulse();
      check("pulses after", pulses, 1);
      $display("test incremental done");
   endtask

   initial begin
      t_abs(36'h303900005, 16'h0001);
      t_abs(36'h000600014, 16'h0003);
      t_abs(36'hFFF600011, 16'h0005);
      t_abs(36'h800000000, 16'h0001);
      t_incr();
      stop_test();
   end
endmodule
